//--- common/kds_pkg.sv
`default_nettype none
package kds_pkg;
	// Internal base rate and the scan timing derived from it.
	localparam int unsigned BASE_FREQ_KHZ = 100;
	localparam int unsigned SCAN_TIME_US  = 5100;
	localparam int unsigned DEBOUNCE_US   = 10300;
	localparam int unsigned KB_ROWS       = 8;
	localparam int unsigned ROW_TICKS     =
		(SCAN_TIME_US * BASE_FREQ_KHZ + KB_ROWS * 1000 - 1) / (KB_ROWS * 1000);
	localparam logic [5:0] ROW_LAST       = 6'(ROW_TICKS - 1);
	localparam logic [1:0] DEB_LAST       = 2'(DEBOUNCE_US / SCAN_TIME_US - 1);
	localparam logic [5:0] BLANK_TICKS    = 6'h04;
	localparam logic [4:0] PRESCALE_RESET = 5'h1F;
	localparam logic [4:0] PRESCALE_MIN   = 5'h02;
	localparam int unsigned FIFO_DEPTH    = 8;
	localparam int unsigned FIFO_WIDTH    = 8;

	// Command opcodes, carried in the top three data bits.
	localparam logic [2:0] CMD_MODE   = 3'h0;
	localparam logic [2:0] CMD_CLOCK  = 3'h1;
	localparam logic [2:0] CMD_RDFIFO = 3'h2;
	localparam logic [2:0] CMD_RDDISP = 3'h3;
	localparam logic [2:0] CMD_WRDISP = 3'h4;
	localparam logic [2:0] CMD_BLANK  = 3'h5;
	localparam logic [2:0] CMD_CLEAR  = 3'h6;
	localparam logic [2:0] CMD_ENDINT = 3'h7;

	// Field positions inside command bytes.
	localparam int unsigned F_AI        = 4;
	localparam int unsigned F_DISP_R    = 4;
	localparam int unsigned F_DISP_16   = 3;
	localparam int unsigned F_DECODE    = 0;
	localparam int unsigned F_INH_A     = 3;
	localparam int unsigned F_INH_B     = 2;
	localparam int unsigned F_BLANK_A   = 1;
	localparam int unsigned F_BLANK_B   = 0;
	localparam int unsigned F_CLR_D     = 4;
	localparam int unsigned F_CLR_D1    = 3;
	localparam int unsigned F_CLR_D0    = 2;
	localparam int unsigned F_CLR_F     = 1;
	localparam int unsigned F_CLR_A     = 0;
	localparam int unsigned F_ERR_MODE  = 4;

	// Clear codes for the display store.
	localparam logic [7:0] CLR_ZERO  = 8'h00;
	localparam logic [7:0] CLR_SPACE = 8'h20;
	localparam logic [7:0] CLR_ONES  = 8'hFF;

	// Input modes, from bits 2:1 of the mode command.
	typedef enum logic [1:0] {
		IN_LOCKOUT  = 2'b00,
		IN_ROLLOVER = 2'b01,
		IN_SENSOR   = 2'b10,
		IN_STROBED  = 2'b11
	} kds_input_t;

	// Source of data reads.
	typedef enum logic {
		RD_FIFO = 1'b0,
		RD_DISP = 1'b1
	} kds_rdsrc_t;

	// All pins that cross into the clock domain, in port order.
	typedef struct packed {
		logic       csN;
		logic       cmdDataSelect;
		logic       rdN;
		logic       wrN;
		logic [7:0] hostData;
		logic [7:0] returnLines;
		logic       shiftIn;
		logic       controlStrobeIn;
	} kds_pins_t;

	// One queued key entry.
	typedef struct packed {
		logic       control;
		logic       shift;
		logic [2:0] row;
		logic [2:0] col;
	} kds_key_t;
endpackage : kds_pkg
`default_nettype wire

//--- core/kds_scanner.sv
// Function
// - Reset selects 16-char left, encoded, lockout, 31.
// - Data bus driven only while chip select and read low.
// - Select line picks command/status versus RAM data.
// - Write strobe accepts, read strobe drives data.
// - Commands latched on write strobe rising edge.
// - Keyboard interrupt follows FIFO, drops during FIFO data reads.
// - Sensor change raises the interrupt.
// - Decode mode gives one-of-four scan.
// - Encode mode gives binary sixteen-position scan.
// - Decode mode shows first four display words.
// - Debounced key queued with shift and control.
// - Strobe rising edge queues return lines.
// - Prescaler and counters make scan timing.
// - Status shows empty, full, count, errors.
// - Status read with select high.
// - Eight-entry FIFO or 64-bit sensor store.
// - Display addresses with optional auto-increment.
// - Nibbles follow scan, masked writes, separate blanking.
// - Blank output during digit switch or command.
// - Sixty-four keys, lockout or rollover.
// - Sensor rows stored each scan until a change is flagged, shift ignored.
// - Prescale values below two act as two.
`default_nettype none

// Small FIFO; the filling side sees inReady low when full.
module kds_fifo
	import kds_pkg::*;
#(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8,
	localparam int unsigned AW   = $clog2(DEPTH),
	localparam int unsigned CW   = $clog2(DEPTH + 1)
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             clear,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady,
	output logic      [CW-1:0]    count
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [CW-1:0]               cnt;
	} kds_fifo_st_t;

	kds_fifo_st_t st;
	kds_fifo_st_t next_st;
	logic         push;
	logic         pop;

	assign inReady  = st.cnt != CW'(DEPTH);
	assign outValid = st.cnt != '0;
	assign outData  = st.mem[st.rp];
	assign count    = st.cnt;

	// Pointers wrap at the depth, so it need not be a power of two.
	always_comb begin
		next_st = st;
		push    = inValid && inReady;
		pop     = outValid && outReady;
		if (push) begin
			next_st.mem[st.wp] = inData;
			next_st.wp         = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + AW'(1);
		end
		if (pop) begin
			next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + AW'(1);
		end
		if (push && !pop) begin
			next_st.cnt = st.cnt + CW'(1);
		end else if (pop && !push) begin
			next_st.cnt = st.cnt - CW'(1);
		end
		if (clear) begin
			next_st.wp  = '0;
			next_st.rp  = '0;
			next_st.cnt = '0;
		end
	end

	// One register stage for the whole FIFO state.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
endmodule : kds_fifo

module kds_scanner
	import kds_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       csN,
	input  wire logic       cmdDataSelect,
	input  wire logic       rdN,
	input  wire logic       wrN,
	input  wire logic [7:0] hostDataIn,
	output logic      [7:0] hostDataOut,
	output logic            hostDataOe,
	output logic            irq,
	output logic      [3:0] scanLines,
	input  wire logic [7:0] returnLines,
	input  wire logic       shiftIn,
	input  wire logic       controlStrobeIn,
	output logic      [3:0] displayNibbleA,
	output logic      [3:0] displayNibbleB,
	output logic            displayBlankN
);
	typedef struct packed {
		kds_pins_t              s1;
		kds_pins_t              s2;
		kds_pins_t              s3;
		kds_pins_t              flt;
		logic                   dispRight;
		logic                   disp16;
		kds_input_t             inMode;
		logic                   decode;
		logic [4:0]             prescale;
		logic [4:0]             preCnt;
		logic [5:0]             tickCnt;
		logic [3:0]             scanCnt;
		kds_rdsrc_t             rdSrc;
		logic                   dispAi;
		logic [3:0]             dispAddr;
		logic                   sensAi;
		logic [2:0]             sensAddr;
		logic                   inhA;
		logic                   inhB;
		logic                   blankA;
		logic                   blankB;
		logic [7:0]             clrCode;
		logic                   errMode;
		logic                   ovr;
		logic                   und;
		logic                   sensIrq;
		logic                   irq;
		logic [15:0][7:0]       disp;
		logic [7:0][7:0]        sensor;
		logic [63:0]            keyDown;
		logic                   candValid;
		logic [2:0]             candRow;
		logic [2:0]             candCol;
		logic [1:0]             candAge;
		logic [7:0]             readData;
		logic [3:0]             outA;
		logic [3:0]             outB;
		logic                   blankN;
		logic [3:0]             scanOut;
	} kds_st_t;

	kds_st_t    st;
	kds_st_t    next_st;
	kds_pins_t  pinsNow;
	kds_pins_t  p;
	logic [4:0] divisor;
	logic       baseTick;
	logic       rowEnd;
	logic       wrRise;
	logic       rdRise;
	logic       stbRise;
	logic       reading;
	logic [2:0] kbRow;
	logic [3:0] dAddr;
	logic [7:0] closed;
	logic [7:0] status;
	logic       found;
	logic [2:0] newCol;
	logic       fifoPush;
	kds_key_t   fifoPushData;
	logic       fifoPop;
	logic       fifoClr;
	logic       fifoInReady;
	logic       fifoOutValid;
	logic [7:0] fifoOutData;
	logic [3:0] fifoCount;

	assign pinsNow = {csN, cmdDataSelect, rdN, wrN, hostDataIn, returnLines, shiftIn,
		controlStrobeIn};

	// Output enable follows the raw pins so the bus is released at once.
	assign hostDataOe     = !csN && !rdN;
	assign hostDataOut    = st.readData;
	assign irq            = st.irq;
	assign scanLines      = st.scanOut;
	assign displayNibbleA = st.outA;
	assign displayNibbleB = st.outB;
	assign displayBlankN  = st.blankN;

	kds_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.clear   (fifoClr),
		.inValid (fifoPush),
		.inData  (fifoPushData),
		.inReady (fifoInReady),
		.outValid(fifoOutValid),
		.outData (fifoOutData),
		.outReady(fifoPop),
		.count   (fifoCount)
	);

	// Reset state; the filtered pins start at their idle high level.
	function automatic kds_st_t resetState();
		kds_st_t r;
		r          = '0;
		r.s1       = '1;
		r.s2       = '1;
		r.s3       = '1;
		r.flt      = '1;
		r.disp16   = 1'b1;
		r.inMode   = IN_LOCKOUT;
		r.prescale = PRESCALE_RESET;
		// The sensor store starts at the open level of the pulled-up returns,
		// so entering sensor mode with nothing closed raises no false change.
		r.sensor   = '1;
		r.blankN   = 1'b0;
		return r;
	endfunction : resetState

	// All behaviour; the clear command is done in one cycle, so the busy bit stays low.
	always_comb begin
		next_st      = st;
		fifoPush     = 1'b0;
		fifoPushData = '0;
		fifoPop      = 1'b0;
		fifoClr      = 1'b0;
		found        = 1'b0;
		newCol       = '0;
		p            = st.flt;
		closed       = ~p.returnLines;
		// A pin change counts only once stages two and three agree.
		next_st.s1  = pinsNow;
		next_st.s2  = st.s1;
		next_st.s3  = st.s2;
		next_st.flt = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.flt);
		wrRise      = !st.flt.wrN && next_st.flt.wrN;
		rdRise      = !st.flt.rdN && next_st.flt.rdN;
		stbRise     = !st.flt.controlStrobeIn && next_st.flt.controlStrobeIn;
		reading     = !p.csN && !p.rdN;
		// Timing chain.
		divisor  = (st.prescale < PRESCALE_MIN) ? PRESCALE_MIN : st.prescale;
		baseTick = st.preCnt >= divisor - 5'h01;
		rowEnd   = baseTick && st.tickCnt == ROW_LAST;
		next_st.preCnt = baseTick ? 5'h00 : st.preCnt + 5'h01;
		if (baseTick) begin
			next_st.tickCnt = st.tickCnt + 6'h01;
		end
		if (rowEnd) begin
			next_st.scanCnt = st.scanCnt + 4'h1;
		end
		kbRow = st.decode ? {1'b0, st.scanCnt[1:0]} : st.scanCnt[2:0];
		// Status word: busy, sensor error, overrun, underrun, full, count.
		status = {1'b0, st.errMode && st.inMode == IN_SENSOR && |(~st.sensor),
			st.ovr, st.und, fifoCount[3], fifoCount[2:0]};
		// Read data tracks its source until the strobe is low, then holds.
		if (!reading) begin
			if (p.cmdDataSelect) begin
				next_st.readData = status;
			end else if (st.rdSrc == RD_DISP) begin
				next_st.readData = st.disp[st.dispAddr];
			end else if (st.inMode == IN_SENSOR) begin
				next_st.readData = st.sensor[st.sensAddr];
			end else begin
				next_st.readData = fifoOutData;
			end
		end
		// The end of a data read advances the selected source.
		if (rdRise && !p.csN && !p.cmdDataSelect) begin
			if (st.rdSrc == RD_DISP) begin
				if (st.dispAi) begin
					next_st.dispAddr = st.dispAddr + 4'h1;
				end
			end else if (st.inMode == IN_SENSOR) begin
				if (st.sensAi) begin
					next_st.sensAddr = st.sensAddr + 3'h1;
				end
			end else if (fifoOutValid) begin
				fifoPop = 1'b1;
			end else begin
				next_st.und = 1'b1;
			end
		end
		// Host writes, taken at the rising write strobe.
		if (wrRise && !p.csN) begin
			if (p.cmdDataSelect) begin
				case (p.hostData[7:5])
					CMD_MODE: begin
						next_st.dispRight = p.hostData[F_DISP_R];
						next_st.disp16    = p.hostData[F_DISP_16];
						next_st.inMode    = kds_input_t'(p.hostData[2:1]);
						next_st.decode    = p.hostData[F_DECODE];
					end
					CMD_CLOCK: begin
						next_st.prescale = p.hostData[4:0];
					end
					CMD_RDFIFO: begin
						next_st.rdSrc    = RD_FIFO;
						next_st.sensAi   = p.hostData[F_AI];
						next_st.sensAddr = p.hostData[2:0];
					end
					CMD_RDDISP, CMD_WRDISP: begin
						// Only the read command switches the read source.
						if (p.hostData[5]) begin
							next_st.rdSrc = RD_DISP;
						end
						next_st.dispAi   = p.hostData[F_AI];
						next_st.dispAddr = p.hostData[3:0];
					end
					CMD_BLANK: begin
						next_st.inhA   = p.hostData[F_INH_A];
						next_st.inhB   = p.hostData[F_INH_B];
						next_st.blankA = p.hostData[F_BLANK_A];
						next_st.blankB = p.hostData[F_BLANK_B];
					end
					CMD_CLEAR: begin
						if (!p.hostData[F_CLR_D]) begin
							next_st.clrCode = CLR_ZERO;
						end else if (!p.hostData[F_CLR_D1]) begin
							next_st.clrCode = CLR_ZERO;
						end else begin
							next_st.clrCode = p.hostData[F_CLR_D0] ? CLR_ONES : CLR_SPACE;
						end
						if (p.hostData[F_CLR_D] || p.hostData[F_CLR_A]) begin
							next_st.disp = {16{next_st.clrCode}};
						end
						if (p.hostData[F_CLR_F] || p.hostData[F_CLR_A]) begin
							fifoClr          = 1'b1;
							next_st.ovr      = 1'b0;
							next_st.und      = 1'b0;
							next_st.sensIrq  = 1'b0;
							next_st.sensAddr = 3'h0;
						end
						if (p.hostData[F_CLR_A]) begin
							next_st.preCnt  = 5'h00;
							next_st.tickCnt = 6'h00;
							next_st.scanCnt = 4'h0;
						end
					end
					CMD_ENDINT: begin
						next_st.sensIrq = 1'b0;
						next_st.errMode = p.hostData[F_ERR_MODE];
					end
					default: begin
						next_st.errMode = st.errMode;
					end
				endcase
			end else begin
				// Masked nibble writes keep the other port untouched.
				if (!st.inhA) begin
					next_st.disp[st.dispAddr][7:4] = p.hostData[7:4];
				end
				if (!st.inhB) begin
					next_st.disp[st.dispAddr][3:0] = p.hostData[3:0];
				end
				if (st.dispAi) begin
					next_st.dispAddr = st.dispAddr + 4'h1;
				end
			end
		end
		// Row sampling at the end of each scan position.
		if (rowEnd) begin
			case (st.inMode)
				IN_LOCKOUT, IN_ROLLOVER: begin
					for (int c = 0; c < 8; c++) begin
						if (!closed[c]) begin
							next_st.keyDown[{kbRow, 3'(c)}] = 1'b0;
						end
					end
					if (st.candValid && st.candRow == kbRow) begin
						if (!closed[st.candCol]) begin
							next_st.candValid = 1'b0;
						end else if (st.candAge == DEB_LAST) begin
							// Key held across the debounce wait; queue it.
							fifoPush          = 1'b1;
							fifoPushData      = {p.controlStrobeIn, p.shiftIn, kbRow,
								st.candCol};
							next_st.keyDown[{kbRow, st.candCol}] = 1'b1;
							next_st.candValid = 1'b0;
						end else begin
							next_st.candAge = st.candAge + 2'h1;
						end
					end else if (!st.candValid) begin
						// Lockout waits for all keys up; rollover takes any new key.
						for (int c = 7; c >= 0; c--) begin
							if (closed[c] && !st.keyDown[{kbRow, 3'(c)}] &&
									(st.inMode == IN_ROLLOVER || st.keyDown == '0)) begin
								found  = 1'b1;
								newCol = 3'(c);
							end
						end
						if (found) begin
							next_st.candValid = 1'b1;
							next_st.candRow   = kbRow;
							next_st.candCol   = newCol;
							next_st.candAge   = 2'h0;
						end
					end
				end
				IN_SENSOR: begin
					// Store writes stop while an unacknowledged change stands.
					if (!st.sensIrq) begin
						next_st.sensor[kbRow] = p.returnLines;
						if (st.sensor[kbRow] != p.returnLines) begin
							next_st.sensIrq = 1'b1;
						end
					end
				end
				default: begin
					next_st.candValid = 1'b0;
				end
			endcase
		end
		if (st.inMode == IN_STROBED && stbRise) begin
			fifoPush     = 1'b1;
			fifoPushData = p.returnLines;
		end
		// A push refused by a full FIFO is lost and flagged.
		if (fifoPush && !fifoInReady) begin
			next_st.ovr = 1'b1;
		end
		// Interrupt: FIFO level in key modes, change flag in sensor mode.
		if (st.inMode == IN_SENSOR) begin
			next_st.irq = next_st.sensIrq;
		end else begin
			next_st.irq = fifoOutValid && !fifoClr && !(reading && !p.cmdDataSelect &&
				st.rdSrc == RD_FIFO);
		end
		// Display and scan outputs, one register behind the counter.
		if (st.decode) begin
			next_st.scanOut = 4'h1 << st.scanCnt[1:0];
			dAddr           = {2'b00, st.scanCnt[1:0]};
		end else begin
			next_st.scanOut = st.scanCnt;
			dAddr           = st.disp16 ? st.scanCnt : {1'b0, st.scanCnt[2:0]};
		end
		next_st.outA   = st.blankA ? st.clrCode[7:4] : st.disp[dAddr][7:4];
		next_st.outB   = st.blankB ? st.clrCode[3:0] : st.disp[dAddr][3:0];
		next_st.blankN = !(st.tickCnt < BLANK_TICKS || (st.blankA && st.blankB));
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= resetState();
		end else if (ce) begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_bus_float: assert property (csN |-> !hostDataOe)
		else $error("Data bus enabled while chip select high.");
	chk_reset_mode: assert property ($past(rst) |-> st.prescale == PRESCALE_RESET &&
		st.disp16 && !st.dispRight && !st.decode && st.inMode == IN_LOCKOUT)
		else $error("Reset state wrong.");
	chk_decode_onehot: assert property (ce && st.decode |=> $onehot(scanLines))
		else $error("Decoded scan not one-hot.");
	chk_encode_count: assert property (ce && !st.decode && !$past(st.decode) |=>
		scanLines == $past(st.scanCnt))
		else $error("Encoded scan does not follow counter.");
	chk_tick_spacing: assert property (ce && baseTick |=> !baseTick)
		else $error("Base tick faster than divide by two.");
	chk_clock_cmd: assert property (ce && wrRise && !p.csN && p.cmdDataSelect &&
		p.hostData[7:5] == CMD_CLOCK |=> st.prescale == $past(p.hostData[4:0]))
		else $error("Prescale command not latched.");
	chk_irq_empty: assert property (ce && st.inMode != IN_SENSOR && fifoCount == '0
		|=> !irq)
		else $error("Interrupt high with empty FIFO.");
	chk_strobe_push: assert property (st.inMode == IN_STROBED && stbRise |-> fifoPush)
		else $error("Strobe edge not queued.");
	chk_overrun_flag: assert property (ce && fifoPush && !fifoInReady |=> status[5])
		else $error("Overrun not flagged.");
	chk_pop_count: assert property (ce && fifoPop && !fifoPush && !fifoClr |=>
		fifoCount == $past(fifoCount) - 4'h1)
		else $error("FIFO read did not remove an entry.");
	chk_blank_cmd: assert property (ce && st.blankA && st.blankB |=> !displayBlankN)
		else $error("Blank output not asserted.");

	cov_key_queued: cover property (rowEnd && fifoPush && st.inMode == IN_LOCKOUT);
	cov_fifo_full: cover property (fifoCount == 4'h8);
	cov_sensor_irq: cover property (st.inMode == IN_SENSOR ##1 irq);
endmodule : kds_scanner
`default_nettype wire

//--- dv/kds_host_model.sv
`default_nettype none
// Host side of the parallel port, driving one byte access at a time.
module kds_host_model
	import kds_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic [7:0] busIn,
	output logic            csN,
	output logic            cmdDataSelect,
	output logic            rdN,
	output logic            wrN,
	output logic      [7:0] busOut,
	output logic            rdPulse,
	output logic      [7:0] rdData
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle levels; the data lines show the inverse of the last byte once released.
	initial begin
		csN = 1'b1;
		cmdDataSelect = 1'b1;
		rdN = 1'b1;
		wrN = 1'b1;
		busOut = 8'h00;
		rdPulse = 1'b0;
		rdData = 8'h00;
	end

	// Select and data settle before the strobe and stay well past its rise,
	// because the pin filter needs three cycles to see every change.
	task automatic access(input logic sel, input logic isRead, input logic note,
		input logic [7:0] b);
		@(negedge sys_clk);
		csN = 1'b0;
		cmdDataSelect = sel;
		busOut = b;
		repeat (3) @(negedge sys_clk);
		rdN = !isRead;
		wrN = isRead;
		// Read data is taken at a falling edge, well after the held value settled.
		repeat (5) @(negedge sys_clk);
		rdData = busIn;
		rdPulse = isRead && note;
		@(negedge sys_clk);
		rdPulse = 1'b0;
		rdN = 1'b1;
		wrN = 1'b1;
		repeat (5) @(negedge sys_clk);
		csN = 1'b1;
		busOut = ~b;
	endtask : access
endmodule : kds_host_model
`default_nettype wire

//--- dv/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        sys_clk         = 1'b0;
	logic        rst             = 1'b1;
	logic        shiftIn         = 1'b1;
	logic        controlStrobeIn = 1'b1;
	logic        keyOn           = 1'b0;
	logic [2:0]  keyRow          = 3'h0;
	logic [2:0]  keyCol          = 3'h0;
	logic [7:0]  rlDrive         = 8'hFF;
	logic [7:0]  returnLines     = 8'hFF;
	logic [31:0] seed            = 32'h6B6D;
	logic [7:0]  disp [16];
	logic [7:0]  vals [9];
	logic [15:0] expQ [$];
	logic [7:0]  v;
	int          nErrors         = 0;
	int          nCompared       = 0;
	wire logic   csN, cmdDataSelect, rdN, wrN, hostDataOe, irq, rdPulse, displayBlankN;
	wire logic [7:0] hostDataOut, busOut, rdData, busWire;
	wire logic [3:0] scanLines, displayNibbleA, displayNibbleB;

	// The device wins the shared lines only while it enables them.
	assign busWire = hostDataOe ? hostDataOut : busOut;

	kds_host_model host (.sys_clk(sys_clk), .busIn(busWire), .csN(csN),
		.cmdDataSelect(cmdDataSelect), .rdN(rdN), .wrN(wrN), .busOut(busOut),
		.rdPulse(rdPulse), .rdData(rdData));

	kds_scanner uut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .csN(csN),
		.cmdDataSelect(cmdDataSelect), .rdN(rdN), .wrN(wrN), .hostDataIn(busWire),
		.hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .irq(irq),
		.scanLines(scanLines), .returnLines(returnLines), .shiftIn(shiftIn),
		.controlStrobeIn(controlStrobeIn), .displayNibbleA(displayNibbleA),
		.displayNibbleB(displayNibbleB), .displayBlankN(displayBlankN));

	// Clock of 50 ns.
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	// One key pulls its column low while its row is scanned.
	always @(negedge sys_clk) begin
		returnLines <= (keyOn && scanLines[2:0] == keyRow) ? ~(8'h01 << keyCol) : rlDrive;
	end

	function automatic logic [7:0] rnd8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd8

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		nCompared++;
		if (seen !== want) begin
			nErrors++;
			$display("unexpected at %0t: seen %h, expected %h", $time, seen, want);
		end
	endtask : check

	task automatic endSim();
		$display("compared %0d, errors %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : endSim

	// Each read that pulses rdPulse takes the oldest note; one with no note queued always mismatches.
	always @(posedge rdPulse) begin
		if (expQ.size() == 0) begin
			check(16'(rdData), 16'hFFFF);
		end else begin
			check(16'(rdData), expQ.pop_front());
		end
	end

	task automatic wr(input logic sel, input logic [7:0] b);
		host.access(sel, 1'b0, 1'b0, b);
	endtask : wr

	task automatic rd(input logic sel, input logic [7:0] e);
		expQ.push_back(16'(e));
		host.access(sel, 1'b1, 1'b1, 8'h5A);
	endtask : rd

	task automatic strobe(input logic [7:0] b);
		@(negedge sys_clk);
		rlDrive = b;
		controlStrobeIn = 1'b0;
		repeat (6) @(negedge sys_clk);
		controlStrobeIn = 1'b1;
		repeat (6) @(negedge sys_clk);
	endtask : strobe

	// Follows three row changes; row length, step, blanking and shown word are checked.
	task automatic scan_rows(input logic dec, input int ticks);
		logic [3:0] prev;
		int n;
		@(negedge sys_clk);
		prev = scanLines;
		n = 0;
		for (int r = 0; r < 3; r++) begin
			while (scanLines === prev && n < 4000) begin
				@(negedge sys_clk);
				n++;
			end
			if (r > 0) begin
				check(16'(n), 16'(ticks));
				check(16'(scanLines), 16'(dec ? {prev[2:0], prev[3]} : prev + 4'h1));
			end
			prev = scanLines;
			repeat (3) @(negedge sys_clk);
			check(16'(displayBlankN), 16'h0);
			repeat (ticks / 16 + 4) @(negedge sys_clk);
			check(16'(displayBlankN), 16'h1);
			// A one-hot scan is turned back into its digit index by hand.
			v = disp[dec ? {2'b00, scanLines[3] | scanLines[2], scanLines[3] | scanLines[1]}
				: scanLines];
			if (r > 0) check(16'({displayNibbleA, displayNibbleB}), 16'(v));
			n = ticks / 16 + 7;
		end
	endtask : scan_rows

	// Watchdog well beyond the expected run of some twenty-three thousand cycles.
	initial begin
		repeat (60000) @(posedge sys_clk);
		nErrors++;
		endSim();
	end

	// Main sequence; inputs move on falling edges only.
	initial begin
		for (int i = 0; i < 16; i++) disp[i] = 8'h00;
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		check(16'(hostDataOe), 16'h0);
		rd(1'b1, 8'h00);
		scan_rows(1'b0, 1984);
		wr(1'b1, 8'h20);
		wr(1'b1, 8'h0E);
		wr(1'b1, 8'h40);
		for (int i = 0; i < 9; i++) begin
			vals[i] = rnd8();
			strobe(vals[i]);
		end
		rlDrive = 8'hFF;
		rd(1'b1, 8'h28);
		for (int i = 0; i < 8; i++) rd(1'b0, vals[i]);
		rd(1'b1, 8'h20);
		host.access(1'b0, 1'b1, 1'b0, 8'h5A);
		rd(1'b1, 8'h30);
		wr(1'b1, 8'hC2);
		rd(1'b1, 8'h00);
		wr(1'b1, 8'h08);
		wr(1'b1, 8'h90);
		for (int i = 0; i < 16; i++) begin
			disp[i] = rnd8();
			wr(1'b0, disp[i]);
		end
		wr(1'b1, 8'h70);
		for (int i = 0; i < 16; i++) rd(1'b0, disp[i]);
		wr(1'b1, 8'hA8);
		wr(1'b1, 8'h80);
		v = rnd8();
		wr(1'b0, v);
		disp[0][3:0] = v[3:0];
		wr(1'b1, 8'hA0);
		wr(1'b1, 8'h60);
		rd(1'b0, disp[0]);
		scan_rows(1'b0, 128);
		wr(1'b1, 8'h09);
		scan_rows(1'b1, 128);
		wr(1'b1, 8'hA3);
		repeat (20) @(negedge sys_clk);
		check(16'(displayBlankN), 16'h0);
		wr(1'b1, 8'hA0);
		wr(1'b1, 8'h0C);
		repeat (2200) @(negedge sys_clk);
		wr(1'b1, 8'hE0);
		repeat (2200) @(negedge sys_clk);
		check(16'(irq), 16'h0);
		keyRow = 3'h3;
		keyCol = 3'h5;
		keyOn = 1'b1;
		repeat (2200) @(negedge sys_clk);
		check(16'(irq), 16'h1);
		wr(1'b1, 8'h43);
		rd(1'b0, 8'hDF);
		keyOn = 1'b0;
		wr(1'b1, 8'h08);
		wr(1'b1, 8'hC2);
		wr(1'b1, 8'h40);
		v = rnd8();
		shiftIn = v[0];
		controlStrobeIn = v[1];
		keyRow = 3'h2;
		keyCol = 3'h6;
		keyOn = 1'b1;
		repeat (4000) @(negedge sys_clk);
		check(16'(irq), 16'h1);
		keyOn = 1'b0;
		rd(1'b0, {v[1], v[0], 3'h2, 3'h6});
		repeat (10) @(negedge sys_clk);
		check(16'(irq), 16'h0);
		// Clear the display to all ones, read back its first two words, then queue a key in rollover.
		wr(1'b1, 8'hDC);
		wr(1'b1, 8'h70);
		rd(1'b0, 8'hFF);
		rd(1'b0, 8'hFF);
		wr(1'b1, 8'h40);
		wr(1'b1, 8'h0A);
		keyRow = 3'h5;
		keyCol = 3'h1;
		keyOn = 1'b1;
		repeat (4000) @(negedge sys_clk);
		keyOn = 1'b0;
		rd(1'b0, {v[1], v[0], 3'h5, 3'h1});
		endSim();
	end
endmodule : testbench
`default_nettype wire
